// [src/tcs_defs.svh]
/*
 * Offsets, field positions, reset values and masks of the timer control/status block.
 * Assumes a 24-bit register address space and a 24-bit data word.
 */
`ifndef TCS_DEFS_SVH
`define TCS_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TCS_CTL0_OFS 24'h0f_ff8f
`define TCS_CTL1_OFS 24'hff_ff8b
`define TCS_CTL2_OFS 24'hff_ff87
`define TCS_CMP0_OFS 24'hff_ff8d
`define TCS_CMP1_OFS 24'hff_ff89
`define TCS_CMP2_OFS 24'hff_ff85
`define TCS_CNT0_OFS 24'hff_ff8c
`define TCS_CNT1_OFS 24'hff_ff88
`define TCS_CNT2_OFS 24'hff_ff84
`define TCS_IRQ_STAT_OFS 24'hff_ff90
`define TCS_IRQ_EN_OFS 24'hff_ff91
`define TCS_IRQ_CLR_OFS 24'hff_ff92

// ----------------------------------------------------------------
// Control/status field positions
// ----------------------------------------------------------------
`define TCS_RUN_BIT 0
`define TCS_OVF_IE_BIT 1
`define TCS_CMP_IE_BIT 2
`define TCS_MODE_LSB 4
`define TCS_MODE_MSB 7
`define TCS_DIR_BIT 11
`define TCS_PIN_IN_BIT 12
`define TCS_PIN_OUT_BIT 13
`define TCS_PRESCALE_BIT 15
`define TCS_OVF_FLAG_BIT 20
`define TCS_CMP_FLAG_BIT 21

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define TCS_CTL_RESET 24'h00_0000
`define TCS_CTL_WR_MASK 24'h00_abf7
`define TCS_IRQ_EN_RESET 6'h3f
`define TCS_HALF_DIV 2

`endif

// [src/tcs_pkg.sv]
/*
 * Types shared by the timer control/status block.
 * Assumes 24-bit address and data on the register port.
 */
`default_nettype none

package tcs_pkg;
   localparam int unsigned NUM_CHAN = 3;

   typedef struct packed {
      logic [23:0] addr;
      logic [23:0] wdata;
      logic wr;
      logic rd;
   } tcs_bus_req_t;

   typedef struct packed {
      logic overflow;
      logic compare;
   } tcs_event_t;
endpackage

`default_nettype wire

// [src/tcs_tick_gen.sv]
/*
 * Count-enable pulses: one at half the system clock, one from the prescaler.
 * Assumes a single clock and a synchronous active-low reset.
 */
`include "tcs_defs.svh"
`default_nettype none

module tcs_tick_gen #(
   parameter int unsigned PRESCALE_DIV = 4
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Tick pulses
   output logic halfTick,
   output logic preTick
);
   initial begin
      if (PRESCALE_DIV < 1 || PRESCALE_DIV > 65536) begin
         $error("PRESCALE_DIV must lie between 1 and 65536");
      end
   end

   logic halfPhase_r;
   logic [15:0] preCount_r;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         halfPhase_r <= 1'b0;
      end else begin
         halfPhase_r <= ~halfPhase_r;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         preCount_r <= 16'h0000;
      end else if (preCount_r == 16'(PRESCALE_DIV - 1)) begin
         preCount_r <= 16'h0000;
      end else begin
         preCount_r <= preCount_r + 16'h0001;
      end
   end

   assign halfTick = halfPhase_r;
   assign preTick = (preCount_r == 16'(PRESCALE_DIV - 1));
endmodule // tcs_tick_gen

`default_nettype wire

// [src/tcs_counter.sv]
/*
 * One free-running timer counter with compare match and wraparound events.
 * Assumes tick is a one-cycle enable and compareVal is held by the caller.
 */
`default_nettype none

module tcs_counter #(
   parameter int unsigned WIDTH = 24
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Control
   input wire logic run,
   input wire logic tick,
   input wire logic [WIDTH-1:0] compareVal,
   // State and events
   output logic [WIDTH-1:0] count,
   output logic wrapPulse,
   output logic matchPulse
);
   initial begin
      if (WIDTH < 2) begin
         $error("WIDTH must be at least two");
      end
   end

   logic [WIDTH-1:0] count_r;
   logic [WIDTH-1:0] count_nxt;

   assign count_nxt = count_r + {{(WIDTH-1){1'b0}}, 1'b1};

   // A stopped timer restarts from zero, so a restart never reports a stale match.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         count_r <= '0;
         wrapPulse <= 1'b0;
         matchPulse <= 1'b0;
      end else begin
         wrapPulse <= 1'b0;
         matchPulse <= 1'b0;
         if (!run) begin
            count_r <= '0;
         end else if (tick) begin
            count_r <= count_nxt;
            wrapPulse <= (count_r == {WIDTH{1'b1}});
            matchPulse <= (count_nxt == compareVal);
         end
      end
   end

   assign count = count_r;
endmodule // tcs_counter

`default_nettype wire

// [src/tcs_timer_block.sv]
/*
 * Three timer channels with control/status, compare and count registers,
 * a shared interrupt status/enable/clear group and one interrupt output.
 * Assumes a register master that issues one-cycle strobes, never both at once,
 * and takes read data in the cycle after the read strobe.
 */
// The plain strobed port is this design's own decision.
`include "tcs_defs.svh"
`default_nettype none

module tcs_timer_block #(
   parameter int unsigned COUNT_WIDTH = 24,
   parameter int unsigned PRESCALE_DIV = 4
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register port
   input wire tcs_pkg::tcs_bus_req_t busReq,
   output logic [23:0] readData,
   // Interrupt acknowledge, bit 2i overflow and 2i+1 compare of channel i
   input wire logic [5:0] irqServiced,
   // Timer pins, one per channel
   input wire logic [2:0] timerIoPinIn,
   output logic [2:0] timerIoPinOut,
   output logic [2:0] timerIoPinOe,
   // Interrupt
   output logic irq
);
   localparam int unsigned NCH = tcs_pkg::NUM_CHAN;

   initial begin
      if (COUNT_WIDTH != 24) begin
         $error("COUNT_WIDTH must match the 24-bit register word");
      end
      // The prescaler counter is 16 bits wide, which bounds the divide ratio.
      if (PRESCALE_DIV < 1 || PRESCALE_DIV > 65536) begin
         $error("PRESCALE_DIV must lie between 1 and 65536");
      end
   end

   // ----------------------------------------------------------------
   // Address map helpers
   // ----------------------------------------------------------------
   // The maps are functions so that the write decode and the read mux cannot
   // disagree about where a channel's words sit.
   // Channel zero's control word sits apart from the others in the address map.
   function automatic logic [23:0] ctlOfs(input int ch);
      case (ch)
         0: ctlOfs = `TCS_CTL0_OFS;
         1: ctlOfs = `TCS_CTL1_OFS;
         default: ctlOfs = `TCS_CTL2_OFS;
      endcase
   endfunction

   function automatic logic [23:0] cmpOfs(input int ch);
      case (ch)
         0: cmpOfs = `TCS_CMP0_OFS;
         1: cmpOfs = `TCS_CMP1_OFS;
         default: cmpOfs = `TCS_CMP2_OFS;
      endcase
   endfunction

   function automatic logic [23:0] cntOfs(input int ch);
      case (ch)
         0: cntOfs = `TCS_CNT0_OFS;
         1: cntOfs = `TCS_CNT1_OFS;
         default: cntOfs = `TCS_CNT2_OFS;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Count enables
   // ----------------------------------------------------------------
   // Both rates come from one divider pair shared by all channels, so channels
   // that select the same source count in step with each other.
   // A tick is a one-cycle enable; nothing here runs on a derived clock.
   logic halfTick;
   logic preTick;

   tcs_tick_gen #(
      .PRESCALE_DIV(PRESCALE_DIV)
   ) u_tick (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .halfTick(halfTick),
      .preTick(preTick)
   );

   // ----------------------------------------------------------------
   // Shared interrupt group
   // ----------------------------------------------------------------
   // Status bits follow the channel flags, so the status word and the
   // control/status words always agree. The enable word resets to all ones,
   // which leaves the per-channel enable bits as the only gate after reset.
   // The clear word is write-only: a 1 clears the matching flag, a 0 does nothing.
   logic [5:0] irqEnable_r;
   logic [5:0] irqStatus;
   logic [5:0] irqGate;
   logic irq_r;
   logic wrIrqEn;
   logic wrIrqClr;

   assign wrIrqEn = busReq.wr && (busReq.addr == `TCS_IRQ_EN_OFS);
   assign wrIrqClr = busReq.wr && (busReq.addr == `TCS_IRQ_CLR_OFS);

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         irqEnable_r <= `TCS_IRQ_EN_RESET;
      end else if (wrIrqEn) begin
         irqEnable_r <= busReq.wdata[5:0];
      end
   end

   // ----------------------------------------------------------------
   // Channels
   // ----------------------------------------------------------------
   // Each channel keeps its control word, its compare word and its two flags.
   // The flags live outside the control word because hardware sets them and
   // software clears them, while the pin-input bit is sampled and the other stored bits are plain read/write storage.
   // Mode bits are stored and read back but do not change how the counter runs;
   // pin-clocked and capture modes are not built, so only the internal count works.
   logic [23:0] ctl_r [NCH];
   logic [23:0] cmp_r [NCH];
   logic [23:0] cnt [NCH];
   logic [NCH-1:0] pinSample_r;
   tcs_pkg::tcs_event_t flag_r [NCH];

   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_chan
         logic wrCtl;
         logic wrCmp;
         logic tick;
         logic wrapPulse;
         logic matchPulse;
         logic clrOvf;
         logic clrCmp;

         assign wrCtl = busReq.wr && (busReq.addr == ctlOfs(gi));
         assign wrCmp = busReq.wr && (busReq.addr == cmpOfs(gi));

         // Reserved bits are masked off; software is expected to write them as zero.
         // The mask also keeps flag and pin-input positions out of the stored word.
         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               ctl_r[gi] <= `TCS_CTL_RESET;
            end else if (wrCtl) begin
               ctl_r[gi] <= busReq.wdata & `TCS_CTL_WR_MASK;
            end
         end

         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               cmp_r[gi] <= 24'h00_0000;
            end else if (wrCmp) begin
               cmp_r[gi] <= busReq.wdata;
            end
         end

         // Every mode counts the same way, internally, at the rate the prescale bit selects.
         assign tick = ctl_r[gi][`TCS_PRESCALE_BIT] ? preTick : halfTick;

         tcs_counter #(
            .WIDTH(COUNT_WIDTH)
         ) u_cnt (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .run(ctl_r[gi][`TCS_RUN_BIT]),
            .tick(tick),
            .compareVal(cmp_r[gi]),
            .count(cnt[gi]),
            .wrapPulse(wrapPulse),
            .matchPulse(matchPulse)
         );

         // Three ways clear a flag: a 1 written to its control-word bit, a 1 in
         // the clear word, or an acknowledge from the interrupt controller.
         assign clrOvf = (wrCtl && busReq.wdata[`TCS_OVF_FLAG_BIT])
                       || (wrIrqClr && busReq.wdata[2*gi])
                       || irqServiced[2*gi];
         assign clrCmp = (wrCtl && busReq.wdata[`TCS_CMP_FLAG_BIT])
                       || (wrIrqClr && busReq.wdata[2*gi+1])
                       || irqServiced[2*gi+1];

         // A new event in the cycle of its clear keeps the flag set.
         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               flag_r[gi].overflow <= 1'b0;
            end else if (wrapPulse) begin
               flag_r[gi].overflow <= 1'b1;
            end else if (clrOvf) begin
               flag_r[gi].overflow <= 1'b0;
            end
         end

         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               flag_r[gi].compare <= 1'b0;
            end else if (matchPulse) begin
               flag_r[gi].compare <= 1'b1;
            end else if (clrCmp) begin
               flag_r[gi].compare <= 1'b0;
            end
         end

         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               pinSample_r[gi] <= 1'b0;
            end else begin
               // Sampled once per cycle; a read shows the level of the cycle before it.
               pinSample_r[gi] <= timerIoPinIn[gi];
            end
         end

         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               timerIoPinOe[gi] <= 1'b0;
               timerIoPinOut[gi] <= 1'b0;
            end else begin
               // Registered, so a new direction or level shows one cycle late.
               timerIoPinOe[gi] <= ctl_r[gi][`TCS_DIR_BIT];
               timerIoPinOut[gi] <= ctl_r[gi][`TCS_PIN_OUT_BIT];
            end
         end

         assign irqStatus[2*gi] = flag_r[gi].overflow;
         assign irqStatus[2*gi+1] = flag_r[gi].compare;
         assign irqGate[2*gi] = ctl_r[gi][`TCS_OVF_IE_BIT];
         assign irqGate[2*gi+1] = ctl_r[gi][`TCS_CMP_IE_BIT];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Interrupt output
   // ----------------------------------------------------------------
   // The request is registered so that the pin comes straight from a flop; it
   // therefore trails the flag that raises it by one cycle.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(irqStatus & irqGate & irqEnable_r);
      end
   end

   assign irq = irq_r;

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Addresses decode exactly; an unmapped read returns zero and an unmapped
   // write changes nothing. Flag and pin-input bits are filled in from their
   // own stores so that the word reads as one register.
   logic [23:0] rd_nxt;
   logic [23:0] readData_r;

   always_comb begin
      rd_nxt = 24'h00_0000;
      if (busReq.addr == `TCS_IRQ_STAT_OFS) begin
         rd_nxt = {18'h0_0000, irqStatus};
      end else if (busReq.addr == `TCS_IRQ_EN_OFS) begin
         rd_nxt = {18'h0_0000, irqEnable_r};
      end
      for (int ch = 0; ch < NCH; ch++) begin
         if (busReq.addr == ctlOfs(ch)) begin
            rd_nxt = ctl_r[ch];
            rd_nxt[`TCS_PIN_IN_BIT] = pinSample_r[ch];
            rd_nxt[`TCS_OVF_FLAG_BIT] = flag_r[ch].overflow;
            rd_nxt[`TCS_CMP_FLAG_BIT] = flag_r[ch].compare;
         end else if (busReq.addr == cmpOfs(ch)) begin
            rd_nxt = cmp_r[ch];
         end else if (busReq.addr == cntOfs(ch)) begin
            rd_nxt = cnt[ch];
         end
      end
   end

   // Read data stand for exactly one cycle and are zero otherwise.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         readData_r <= 24'h00_0000;
      end else if (busReq.rd) begin
         readData_r <= rd_nxt;
      end else begin
         readData_r <= 24'h00_0000;
      end
   end

   assign readData = readData_r;
endmodule // tcs_timer_block

`default_nettype wire

// [dv/tcs_pin_partner.sv]
/* Far-side model of the three timer pins.
   Assumes the bench sets the level that an outside source puts on each pin. */
`default_nettype none
module tcs_pin_partner (
   // From the bench
   input wire logic [2:0] extLevel,
   // From the block
   input wire logic [2:0] timerIoPinOut,
   input wire logic [2:0] timerIoPinOe,
   // To the block
   output logic [2:0] pinLevel
);
   timeunit 1ns;
   timeprecision 1ns;
   // The block owns the wire while it drives, so the outside level is ignored then.
   always_comb begin
      for (int i = 0; i < 3; i++)
         pinLevel[i] = timerIoPinOe[i] ? timerIoPinOut[i] : extLevel[i];
   end
endmodule // tcs_pin_partner
`default_nettype wire

// [dv/tcs_timer_block_asserts.sv]
/* Checker for the register port, pins and interrupt of the timer block.
   Assumes it is bound to tcs_timer_block and sees only its ports. */
`include "tcs_defs.svh"
`default_nettype none
module tcs_timer_block_asserts (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register port
   input wire tcs_pkg::tcs_bus_req_t busReq,
   input wire logic [23:0] readData,
   // Pins and interrupt
   input wire logic [2:0] timerIoPinIn,
   input wire logic [2:0] timerIoPinOut,
   input wire logic [2:0] timerIoPinOe,
   input wire logic irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic run0_r;
   logic [1:0] stopAge_r;
   wire logic wrCtl0 = busReq.wr && busReq.addr == `TCS_CTL0_OFS;
   wire logic rdCtl0 = busReq.rd && busReq.addr == `TCS_CTL0_OFS;
   // ----------------------------------------------------------------
   // Run bit shadow of channel zero
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n)
         run0_r <= 1'b0;
      else if (wrCtl0)
         run0_r <= busReq.wdata[0];
   end
   always_ff @(posedge ref_clk) begin
      if (!rst_n || run0_r)
         stopAge_r <= 2'd0;
      else if (stopAge_r != 2'd3)
         stopAge_r <= stopAge_r + 2'd1;
   end
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_pin_out_level: assert property (
      wrCtl0 |-> ##2 timerIoPinOut[0] == $past(busReq.wdata[13], 2))
      else $error("Pin output level does not follow the written bit.");
   a_pin_dir_level: assert property (
      wrCtl0 |-> ##2 timerIoPinOe[0] == $past(busReq.wdata[11], 2))
      else $error("Pin direction does not follow the written bit.");
   a_pin_in_read: assert property (
      rdCtl0 && $stable(timerIoPinIn[0]) |=> readData[12] == $past(timerIoPinIn[0]))
      else $error("Pin input bit does not show the pin level.");
   a_ctl_read_back: assert property (
      wrCtl0 ##2 rdCtl0 |=>
         (readData & 24'h00_abf7) == ($past(busReq.wdata, 3) & 24'h00_abf7))
      else $error("Control bits do not read back as written.");
   a_reserved_zero: assert property (
      busReq.rd && busReq.addr == `TCS_CTL1_OFS |=> (readData & 24'hcf_4408) == 24'h00_0000)
      else $error("Reserved control bits read nonzero.");
   a_stopped_count: assert property (
      busReq.rd && busReq.addr == `TCS_CNT0_OFS && stopAge_r == 2'd3 |=> readData == 24'h00_0000)
      else $error("Stopped counter reads nonzero.");
   a_irq_disabled: assert property (
      busReq.wr && busReq.addr == `TCS_IRQ_EN_OFS && busReq.wdata[5:0] == 6'h00
         ##1 !busReq.wr |-> ##1 !irq)
      else $error("Interrupt stays up with all enables off.");
   a_unmapped_zero: assert property (
      busReq.rd && busReq.addr == 24'h00_0000 |=> readData == 24'h00_0000)
      else $error("Unmapped address reads nonzero.");
endmodule // tcs_timer_block_asserts
bind tcs_timer_block tcs_timer_block_asserts u_tcs_timer_block_asserts (
   .ref_clk(ref_clk), .rst_n(rst_n), .busReq(busReq), .readData(readData),
   .timerIoPinIn(timerIoPinIn), .timerIoPinOut(timerIoPinOut),
   .timerIoPinOe(timerIoPinOe), .irq(irq));
`default_nettype wire

// [dv/tcs_timer_block_test.sv]
/* Self-checking bench: register access, pins, clock select, compare flag and interrupt.
   Assumes the pin partner model and the bound checker. Overflow needs 2^24 ticks
   and no load register exists, so wraparound is out of reach in this run. */
`include "tcs_defs.svh"
`default_nettype none
module tcs_timer_block_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk;
   logic rst_n;
   tcs_pkg::tcs_bus_req_t busReq;
   logic [23:0] readData;
   logic [5:0] irqServiced;
   logic [2:0] extLevel;
   logic [2:0] pinLevel;
   logic [2:0] pinOut;
   logic [2:0] pinOe;
   logic irq;
   logic [23:0] rdv;
   logic [23:0] ctlOfs [3] = '{`TCS_CTL0_OFS, `TCS_CTL1_OFS, `TCS_CTL2_OFS};
   int n_errors = 0;
   int comparisons = 0;

   tcs_timer_block #(.COUNT_WIDTH(24), .PRESCALE_DIV(4)) u_tcs_timer_block (
      .ref_clk(ref_clk), .rst_n(rst_n), .busReq(busReq), .readData(readData),
      .irqServiced(irqServiced), .timerIoPinIn(pinLevel), .timerIoPinOut(pinOut),
      .timerIoPinOe(pinOe), .irq(irq));
   tcs_pin_partner u_tcs_pin_partner (.extLevel(extLevel), .timerIoPinOut(pinOut),
      .timerIoPinOe(pinOe), .pinLevel(pinLevel));

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // ----------------------------------------------------------------
   // Access and check tasks
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [23:0] a, input logic [23:0] d);
      @(posedge ref_clk);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      busReq.wr <= 1'b0;
   endtask
   task automatic rd(input logic [23:0] a);
      @(posedge ref_clk);
      busReq <= '{addr: a, wdata: 24'h00_0000, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      busReq.rd <= 1'b0;
      #1 rdv = readData;
   endtask
   task automatic rdChk(input string name, input logic [23:0] a, input logic [23:0] exp);
      rd(a);
      check(name, rdv, exp);
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic irqIs(input logic lvl);
      int k;
      k = 0;
      while (irq !== lvl && k < 100) begin
         @(posedge ref_clk);
         k++;
      end
      #1 check("irq", 24'(irq), 24'(lvl));
   endtask
   task automatic arm;
      wr(`TCS_CTL0_OFS, 24'h00_0000);
      wr(`TCS_CTL0_OFS, 24'h00_0005);
      irqIs(1'b1);
   endtask
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      busReq = '0;
      irqServiced = 6'h00;
      extLevel = 3'b000;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 3; i++)
         rdChk("ctl reset", ctlOfs[i], 24'h00_0000);
      rdChk("irq enable reset", `TCS_IRQ_EN_OFS, 24'h00_003f);
      rdChk("unmapped", 24'h00_0000, 24'h00_0000);
      $display("Test reset done");
      for (int i = 0; i < 3; i++) begin
         wr(ctlOfs[i], 24'h00_2800);
         ticks(2);
         check("pin oe", 24'(pinOe[i]), 24'h00_0001);
         check("pin high", 24'(pinOut[i]), 24'h00_0001);
         rdChk("pin driven", ctlOfs[i], 24'h00_3800);
         wr(ctlOfs[i], 24'h00_0800);
         ticks(2);
         check("pin low", 24'(pinOut[i]), 24'h00_0000);
         wr(ctlOfs[i], 24'h00_0000);
         extLevel[i] <= 1'b1;
         ticks(3);
         check("pin input", 24'(pinOe[i]), 24'h00_0000);
         rdChk("pin in high", ctlOfs[i], 24'h00_1000);
         extLevel[i] <= 1'b0;
         ticks(3);
         rdChk("pin in low", ctlOfs[i], 24'h00_0000);
      end
      $display("Test pins done");
      wr(`TCS_CTL1_OFS, 24'h00_ab06);
      ticks(2);
      rdChk("ctl1 readback", `TCS_CTL1_OFS, 24'h00_bb06);
      wr(`TCS_CTL1_OFS, 24'h00_0000);
      wr(`TCS_CTL0_OFS, 24'h00_0001);
      ticks(40);
      rd(`TCS_CNT0_OFS);
      check("half rate", 24'(rdv >= 17 && rdv <= 22), 24'h00_0001);
      wr(`TCS_CTL0_OFS, 24'h00_0000);
      wr(`TCS_CTL0_OFS, 24'h00_8001);
      ticks(40);
      rd(`TCS_CNT0_OFS);
      check("prescale rate", 24'(rdv >= 8 && rdv <= 12), 24'h00_0001);
      wr(`TCS_CTL0_OFS, 24'h00_0000);
      ticks(3);
      rdChk("stopped", `TCS_CNT0_OFS, 24'h00_0000);
      $display("Test clock select done");
      wr(`TCS_CMP0_OFS, 24'h00_0006);
      arm();
      rdChk("cmp flag", `TCS_CTL0_OFS, 24'h20_0005);
      rdChk("irq status", `TCS_IRQ_STAT_OFS, 24'h00_0002);
      wr(`TCS_CTL0_OFS, 24'h00_0005);
      rdChk("write 0 keeps", `TCS_CTL0_OFS, 24'h20_0005);
      wr(`TCS_IRQ_EN_OFS, 24'h00_0000);
      irqIs(1'b0);
      wr(`TCS_IRQ_EN_OFS, 24'h00_003f);
      irqIs(1'b1);
      wr(`TCS_CTL0_OFS, 24'h00_0001);
      irqIs(1'b0);
      wr(`TCS_CTL0_OFS, 24'h00_0005);
      irqIs(1'b1);
      @(posedge ref_clk);
      irqServiced <= 6'h02;
      @(posedge ref_clk);
      irqServiced <= 6'h00;
      irqIs(1'b0);
      rdChk("serviced", `TCS_CTL0_OFS, 24'h00_0005);
      arm();
      wr(`TCS_CTL0_OFS, 24'h20_0005);
      irqIs(1'b0);
      rdChk("w1c", `TCS_CTL0_OFS, 24'h00_0005);
      arm();
      wr(`TCS_IRQ_CLR_OFS, 24'h00_0002);
      irqIs(1'b0);
      rdChk("clear reg", `TCS_IRQ_STAT_OFS, 24'h00_0000);
      $display("Test compare done");
      final_report();
   end

   initial begin
      repeat (5000) @(posedge ref_clk);
      n_errors++;
      final_report();
   end
endmodule // tcs_timer_block_test
`default_nettype wire
